//--- eda_map.svh
// constants of the data eeprom overlay: window, widths, timing defaults
// assumes inclusion by bare name from the package and the modules
`ifndef EDA_MAP_SVH
`define EDA_MAP_SVH

`define EDA_ADDR_W 16
`define EDA_DATA_W 8
`define EDA_DEPTH 32'h0000_0800
`define EDA_IDX_W 11
`define EDA_BASE 16'h0000
`define EDA_LAST 16'h07FF
`define EDA_CNT_W 16
`define EDA_PROG_CYC 16'h01F4
`define EDA_CNT_ONE 16'h0001
`define EDA_CNT_ZERO 16'h0000
`define EDA_BYTE_ZERO 8'h00
`define EDA_ADDR_ZERO 16'h0000

`endif

//--- eda_pkg.sv
// types of the data eeprom overlay
// assumes eda_map.svh is on the include path
`include "eda_map.svh"

package eda_pkg;

   typedef enum logic [0:0] {
      EDA_IDLE = 1'b0,
      EDA_PROG = 1'b1
   } eda_state_t;

   typedef struct packed {
      eda_state_t state;
      logic [`EDA_CNT_W-1:0] cnt;
      logic rd_pend;
      logic [`EDA_DATA_W-1:0] rdata;
      logic rvalid;
      logic ram_req;
      logic ram_we;
      logic [`EDA_ADDR_W-1:0] ram_addr;
      logic [`EDA_DATA_W-1:0] ram_wdata;
      logic refused;
      logic prog_done;
   } eda_regs_t;

endpackage : eda_pkg

//--- eda_mem.sv
// byte array behind the eeprom window, registered read data
// assumes one clock; write and read strobes come from the access logic
`timescale 1ns/10ps
`include "eda_map.svh"

module eda_mem #(
   parameter int DEPTH = `EDA_DEPTH,
   parameter int IDX_W = `EDA_IDX_W,
   parameter int DATA_W = `EDA_DATA_W
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [IDX_W-1:0] idx_i,
   input wire logic [DATA_W-1:0] wdata_i,
   output logic [DATA_W-1:0] rdata_o
);

   logic [DATA_W-1:0] cell_r [DEPTH];

   // contents survive reset, as a nonvolatile array must
   always_ff @(posedge clock_i) begin
      if (wr_i) begin
         cell_r[idx_i] <= wdata_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         rdata_o <= cell_r[idx_i];
      end
   end

endmodule : eda_mem

//--- eda_access.sv
// data eeprom overlay on the external-data move path of the core
// assumes core strobes are on clock_i; space enable comes from core logic
`timescale 1ns/10ps
`include "eda_map.svh"

module eda_access
   import eda_pkg::*;
#(
   parameter logic [`EDA_CNT_W-1:0] PROG_CYCLES = `EDA_PROG_CYC
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic xd_req_i,
   input wire logic xd_we_i,
   input wire logic [`EDA_ADDR_W-1:0] xd_addr_i,
   input wire logic [`EDA_DATA_W-1:0] xd_wdata_i,
   input wire logic eeprom_space_enable_i,
   output logic [`EDA_DATA_W-1:0] ee_rdata_o,
   output logic ee_rvalid_o,
   output logic eeprom_programming_busy_o,
   output logic ee_refused_o,
   output logic ee_prog_done_o,
   output logic ram_req_o,
   output logic ram_we_o,
   output logic [`EDA_ADDR_W-1:0] ram_addr_o,
   output logic [`EDA_DATA_W-1:0] ram_wdata_o
);

   eda_regs_t r;
   eda_regs_t r_nxt;
   logic ee_hit;
   logic ee_rd_go;
   logic ee_wr_go;
   logic busy;
   logic [`EDA_DATA_W-1:0] mem_rdata;

   assign busy = (r.state == EDA_PROG);

   // window is the low 2K of the space
   // eeprom seen only with the space enable set
   // only core move strobes reach the array
   assign ee_hit = xd_req_i && eeprom_space_enable_i
                   && (xd_addr_i <= `EDA_LAST);

   // a single byte per write strobe
   assign ee_wr_go = ee_hit && xd_we_i && !busy;
   assign ee_rd_go = ee_hit && !xd_we_i && !busy;

   eda_mem #(
      .DEPTH(`EDA_DEPTH),
      .IDX_W(`EDA_IDX_W),
      .DATA_W(`EDA_DATA_W)
   ) u_mem (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .wr_i(ee_wr_go),
      .rd_i(ee_rd_go),
      .idx_i(xd_addr_i[`EDA_IDX_W-1:0]),
      .wdata_i(xd_wdata_i),
      .rdata_o(mem_rdata)
   );

   always_comb begin
      r_nxt = r;
      r_nxt.rd_pend = ee_rd_go;
      r_nxt.rvalid = r.rd_pend;
      r_nxt.refused = ee_hit && busy;
      r_nxt.prog_done = 1'b0;
      if (r.rd_pend) begin
         r_nxt.rdata = mem_rdata;
      end
      // outside the window or disabled, the plain ram takes it
      r_nxt.ram_req = xd_req_i && !ee_hit;
      if (xd_req_i && !ee_hit) begin
         r_nxt.ram_we = xd_we_i;
         r_nxt.ram_addr = xd_addr_i;
         r_nxt.ram_wdata = xd_wdata_i;
      end
      case (r.state)
         EDA_IDLE: begin
            if (ee_wr_go) begin
               r_nxt.state = EDA_PROG;
               r_nxt.cnt = PROG_CYCLES - `EDA_CNT_ONE;
            end
         end
         EDA_PROG: begin
            // busy drops by itself when the count runs out
            // length set by the cycle parameter
            if (r.cnt == `EDA_CNT_ZERO) begin
               r_nxt.state = EDA_IDLE;
               r_nxt.prog_done = 1'b1;
            end else begin
               r_nxt.cnt = r.cnt - `EDA_CNT_ONE;
            end
         end
         default: begin
            r_nxt.state = EDA_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   assign ee_rdata_o = r.rdata;
   assign ee_rvalid_o = r.rvalid;
   assign eeprom_programming_busy_o = busy;
   assign ee_refused_o = r.refused;
   assign ee_prog_done_o = r.prog_done;
   assign ram_req_o = r.ram_req;
   assign ram_we_o = r.ram_we;
   assign ram_addr_o = r.ram_addr;
   assign ram_wdata_o = r.ram_wdata;

   // helper: length of the current busy stretch
   logic [`EDA_CNT_W-1:0] busy_len_r;
   always_ff @(posedge clock_i) begin
      if (rst_i || !busy) begin
         busy_len_r <= `EDA_CNT_ZERO;
      end else begin
         busy_len_r <= busy_len_r + `EDA_CNT_ONE;
      end
   end

   eeprom_window_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (xd_req_i && eeprom_space_enable_i && !xd_we_i && !busy
       && xd_addr_i <= `EDA_LAST) |-> ##2 ee_rvalid_o)
      else $error("read in window not answered");

   ram_route_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (xd_req_i && !eeprom_space_enable_i) |=>
      (ram_req_o && ram_addr_o == $past(xd_addr_i)
       && ram_we_o == $past(xd_we_i) && ram_wdata_o == $past(xd_wdata_i)))
      else $error("disabled access not sent to ram");

   above_window_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (xd_req_i && xd_addr_i > `EDA_LAST) |=> ram_req_o ##1 !ee_rvalid_o)
      else $error("address above window reached eeprom");

   only_moves_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      $rose(ee_rvalid_o) |-> $past(xd_req_i, 2) && !$past(xd_we_i, 2))
      else $error("read data without a core move");

   byte_write_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (ee_hit && xd_we_i && !busy) |=> busy ##1 ee_rdata_o == $past(ee_rdata_o))
      else $error("eeprom write did not start programming");

   busy_blocks_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (ee_hit && busy) |=> ee_refused_o ##1 !ee_rvalid_o)
      else $error("access served while busy");

   busy_ends_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      // a reset cut of programming ends busy without a done pulse
      $fell(busy) && !$past(rst_i) |->
      ee_prog_done_o && $past(busy_len_r) == PROG_CYCLES
                      - `EDA_CNT_ONE)
      else $error("busy ended at the wrong count");

   busy_bound_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      busy |-> busy_len_r < PROG_CYCLES)
      else $error("busy held longer than programming length");

endmodule : eda_access

//--- eda_core_model.sv
// core model issuing external-data moves one at a time
// assumes the bench calls move from the clock_i domain
`timescale 1ns/10ps
module eda_core_model (
   input wire logic clock_i,
   output logic req_o,
   output logic we_o,
   output logic en_o,
   output logic [15:0] addr_o,
   output logic [7:0] wdata_o
);
   initial begin
      req_o = 1'b0;
      we_o = 1'b0;
      en_o = 1'b0;
      addr_o = 16'h0000;
      wdata_o = 8'h00;
   end
   // enable driven to en, one move, enable cleared
   task automatic move(input logic en, input logic we,
         input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_i);
      #1;
      en_o = en;
      we_o = we;
      addr_o = a;
      wdata_o = d;
      req_o = 1'b1;
      @(posedge clock_i);
      #1;
      req_o = 1'b0;
      en_o = 1'b0;
      // released bus shows no stale value
      addr_o = ~a;
      wdata_o = ~d;
   endtask : move
endmodule : eda_core_model

//--- eda_access_test.sv
// bench for the eeprom overlay, busy length shortened to 4
// assumes eda_core_model plays the core side
`timescale 1ns/10ps
module eda_access_test;
   import eda_pkg::*;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic req, we, en, rv, busy, refd, done, rreq, rwe;
   logic [15:0] addr, raddr;
   logic [7:0] wd, rd, rwd;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   always #5 clock_i = ~clock_i;
   eda_core_model i_core (.clock_i(clock_i), .req_o(req), .we_o(we),
      .en_o(en), .addr_o(addr), .wdata_o(wd));
   eda_access #(.PROG_CYCLES(16'h0004)) i_dut (.clock_i(clock_i),
      .rst_i(rst_i), .xd_req_i(req), .xd_we_i(we), .xd_addr_i(addr),
      .xd_wdata_i(wd), .eeprom_space_enable_i(en), .ee_rdata_o(rd),
      .ee_rvalid_o(rv), .eeprom_programming_busy_o(busy),
      .ee_refused_o(refd), .ee_prog_done_o(done), .ram_req_o(rreq),
      .ram_we_o(rwe), .ram_addr_o(raddr), .ram_wdata_o(rwd));
   task automatic chk(input string nm, input logic [15:0] e, g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task print_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic step;
      @(posedge clock_i);
      #1;
   endtask : step
   // wait for busy clear before a write
   task automatic wait_idle;
      for (int i = 0; i < 20 && busy !== 1'b0; i++) step();
   endtask : wait_idle
   task automatic t_write;
      i_core.move(1'b1, 1'b1, 16'h07FF, 8'h5A);
      chk("busy c1", 16'h0001, {15'h0, busy});
      repeat (3) step();
      chk("busy c4", 16'h0001, {15'h0, busy});
      step();
      chk("busy end", 16'h0000, {15'h0, busy});
      chk("done", 16'h0001, {15'h0, done});
   endtask : t_write
   task automatic t_refuse;
      wait_idle();
      i_core.move(1'b1, 1'b1, 16'h0000, 8'hC3);
      // second write lands in the second busy cycle
      i_core.move(1'b1, 1'b1, 16'h07FF, 8'hFF);
      chk("refused wr", 16'h0001, {15'h0, refd});
      // read lands in the last busy cycle
      i_core.move(1'b1, 1'b0, 16'h07FF, 8'h00);
      chk("refused rd", 16'h0001, {15'h0, refd});
      step();
      chk("no rvalid", 16'h0000, {15'h0, rv});
      wait_idle();
   endtask : t_refuse
   // reset in mid programming: busy drops, contents stay
   task automatic t_reset;
      i_core.move(1'b1, 1'b1, 16'h0123, 8'h3C);
      chk("busy pre rst", 16'h0001, {15'h0, busy});
      rst_i = 1'b1;
      step();
      rst_i = 1'b0;
      chk("busy rst", 16'h0000, {15'h0, busy});
      chk("done rst", 16'h0000, {15'h0, done});
      t_read(16'h0123, 8'h3C);
   endtask : t_reset
   task automatic t_read(input logic [15:0] a, input logic [7:0] e);
      i_core.move(1'b1, 1'b0, a, 8'h00);
      step();
      chk("rvalid", 16'h0001, {15'h0, rv});
      chk("rdata", {8'h00, e}, {8'h00, rd});
   endtask : t_read
   task automatic t_ram(input logic e, w, input logic [15:0] a);
      i_core.move(e, w, a, 8'h77);
      chk("ram_req", 16'h0001, {15'h0, rreq});
      chk("ram_addr", a, raddr);
      chk("ram_we", {15'h0, w}, {15'h0, rwe});
      chk("ram busy", 16'h0000, {15'h0, busy});
   endtask : t_ram
   initial begin
      repeat (3) @(posedge clock_i);
      #1;
      rst_i = 1'b0;
      t_write();
      t_refuse();
      t_read(16'h07FF, 8'h5A);
      t_read(16'h0000, 8'hC3);
      t_reset();
      t_ram(1'b0, 1'b1, 16'h0010);
      chk("ram_wdata", 16'h0077, {8'h00, rwd});
      t_ram(1'b1, 1'b0, 16'h0800);
      print_verdict();
   end
endmodule : eda_access_test
